// ==== src/bihp_cfg.svh ====
// constants for the bidding interrupt host port
`ifndef BIHP_CFG_SVH
`define BIHP_CFG_SVH

// ----------------------------------------------------------------
// register and command addresses
// ----------------------------------------------------------------
`define BIHP_ADDR_W          6
`define BIHP_CMD_ACK_OFF     6'h26
`define BIHP_CMD_ACK_ON      6'h27
`define BIHP_CMD_CUR_UPD     6'h2A
`define BIHP_OFS_CTRL        6'h30
`define BIHP_OFS_VBASE       6'h31
`define BIHP_OFS_MASK0       6'h32
`define BIHP_OFS_MASK1       6'h33
`define BIHP_OFS_MASK2       6'h34
`define BIHP_OFS_CUR         6'h35

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BIHP_RST_CTRL        8'h00
`define BIHP_RST_VBASE       8'h0F
`define BIHP_RST_MASK        18'h00000
`define BIHP_RST_CUR         8'h00
`define BIHP_RST_ACK_EN      1'b1

// ----------------------------------------------------------------
// field layout and codes
// ----------------------------------------------------------------
`define BIHP_FMT_FULL        2'h0
`define BIHP_FMT_CHAN        2'h1
`define BIHP_FMT_TYPE        2'h2
`define BIHP_FMT_INHIBIT     2'h3
`define BIHP_ID_RX_ERR       3'h7
`define BIHP_ID_RX_OK        3'h3
`define BIHP_ID_TX_LO        2'h2
`define BIHP_ID_BREAK        3'h4
`define BIHP_ID_COS          3'h1
`define BIHP_ID_CT           3'h5
`define BIHP_ALL_ONES        8'hFF
`define BIHP_NUM_SRC         18

// ----------------------------------------------------------------
// timing: ref clock edges from cycle start to data acknowledge
// ----------------------------------------------------------------
`define BIHP_ACK_EDGES       2'h2

`endif

// ==== src/bihp_pkg.sv ====
// types for the bidding interrupt host port
package bihp_pkg;
    // synchronised host pins, all kept in their pin polarity
    typedef struct packed {
        logic       chip_select_n;
        logic       read_strobe_n;
        logic       write_strobe_n;
        logic       int_ack_n;
        logic [5:0] addr;
        logic [7:0] data;
    } bihp_pins_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_ACK  = 4'h4,
        ST_HOLD = 4'h8
    } bihp_state_t;

    typedef enum logic [2:0] {
        CY_NONE = 3'h0,
        CY_RD   = 3'h1,
        CY_WR   = 3'h2,
        CY_IA   = 3'h4
    } bihp_cycle_t;
endpackage

// ==== src/bihp_top.sv ====
// bidding interrupt arbiter, current interrupt capture, vector output and host bus handshake
`timescale 1ns/10ps
`include "bihp_cfg.svh"

module bihp_top
    import bihp_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // host bus pins
    input  wire logic        chip_select_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        int_ack_n,
    input  wire logic [5:0]  addr,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    output logic             int_req_n_o,
    output logic             int_req_oe,
    output logic             data_ack_n_o,
    output logic             data_ack_oe,
    // channel status, same clock
    input  wire logic [15:0] rx_fill,
    input  wire logic [15:0] tx_free,
    input  wire logic [15:0] rx_level,
    input  wire logic [15:0] tx_level,
    input  wire logic [3:0]  rx_error,
    input  wire logic [3:0]  break_seen,
    input  wire logic [3:0]  cos_seen,
    input  wire logic [1:0]  ct_timeout,
    // programmable upper bid bits
    input  wire logic [11:0] break_prio,
    input  wire logic [11:0] cos_prio,
    input  wire logic [3:0]  ct_prio
);

    generate
        if (NUM_CH != 4) begin : g_bad_ch
            $error("bihp_top serves exactly four channels");
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin synchroniser, three stages, change accepted when last two agree
    // ----------------------------------------------------------------
    bihp_pins_t pin_s1;
    bihp_pins_t pin_s2;
    bihp_pins_t pin_s3;
    bihp_pins_t pins;
    bihp_pins_t raw_pins;

    assign raw_pins = '{chip_select_n, read_strobe_n, write_strobe_n, int_ack_n, addr, data_in};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_s1 <= '{1'b1, 1'b1, 1'b1, 1'b1, 6'h00, 8'h00};
            pin_s2 <= '{1'b1, 1'b1, 1'b1, 1'b1, 6'h00, 8'h00};
            pin_s3 <= '{1'b1, 1'b1, 1'b1, 1'b1, 6'h00, 8'h00};
            pins   <= '{1'b1, 1'b1, 1'b1, 1'b1, 6'h00, 8'h00};
        end else begin
            pin_s1 <= raw_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pins   <= (pin_s2 & pin_s3) | (pins & (pin_s2 ^ pin_s3));
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]  interrupt_control;
    logic [7:0]  vector_base;
    logic [17:0] interrupt_mask;
    logic [7:0]  current_interrupt;
    logic        ack_en;

    // ----------------------------------------------------------------
    // bid formation
    // ----------------------------------------------------------------
    logic [7:0] bid   [`BIHP_NUM_SRC];
    logic       bid_v [`BIHP_NUM_SRC];

    function automatic logic [1:0] rx_field(input logic [3:0] fill);
        rx_field = fill[3] ? 2'h3 : fill[2:1];
    endfunction

    function automatic logic [2:0] tx_field(input logic [3:0] free);
        tx_field = free[3] ? 3'h7 : free[2:0];
    endfunction

    // fill gate: a programmed level holds the bid back until reached
    function automatic logic level_ok(input logic [3:0] cnt, input logic [3:0] lvl);
        level_ok = (lvl == 4'h0) ? (cnt != 4'h0) : (cnt >= lvl);
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            logic [3:0] rf;
            logic [3:0] tf;
            assign rf = rx_fill[gi*4 +: 4];
            assign tf = tx_free[gi*4 +: 4];
            assign bid[gi]    = {1'b1, rx_field(rf), (rx_error[gi] ? `BIHP_ID_RX_ERR : `BIHP_ID_RX_OK), 2'(gi)};
            assign bid[gi+4]  = {1'b0, tx_field(tf), `BIHP_ID_TX_LO, 2'(gi)};
            assign bid[gi+8]  = {break_prio[gi*3 +: 3], `BIHP_ID_BREAK, 2'(gi)};
            assign bid[gi+12] = {cos_prio[gi*3 +: 3], `BIHP_ID_COS, 2'(gi)};
            assign bid_v[gi]    = interrupt_mask[gi] & level_ok(rf, rx_level[gi*4 +: 4]);
            assign bid_v[gi+4]  = interrupt_mask[gi+4] & level_ok(tf, tx_level[gi*4 +: 4]);
            assign bid_v[gi+8]  = interrupt_mask[gi+8] & break_seen[gi];
            assign bid_v[gi+12] = interrupt_mask[gi+12] & cos_seen[gi];
        end
        for (gi = 0; gi < 2; gi++) begin : g_ct
            // timer zero reports on channel A, timer one on channel C
            assign bid[gi+16]   = {ct_prio[gi*2 +: 2], 1'b0, `BIHP_ID_CT, 2'(gi*2)};
            assign bid_v[gi+16] = interrupt_mask[gi+16] & ct_timeout[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // arbitration: full byte maximum, so channel bits break upper ties
    // ----------------------------------------------------------------
    logic [7:0] winner;
    logic       any_bid;
    logic       over;

    always_comb begin
        winner  = 8'h00;
        any_bid = 1'b0;
        for (int i = 0; i < `BIHP_NUM_SRC; i++) begin
            if (bid_v[i] && (!any_bid || bid[i] > winner)) begin
                winner  = bid[i];
                any_bid = 1'b1;
            end
        end
    end

    assign over = any_bid && (winner[7:2] > interrupt_control[7:2]);

    // request path never touches current interrupt
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_req_oe <= 1'b0;
        end else begin
            int_req_oe <= over;
        end
    end

    // open drain: only ever pulls low
    assign int_req_n_o  = 1'b0;
    assign data_ack_n_o = 1'b0;

    // ----------------------------------------------------------------
    // host cycle sequencer
    // ----------------------------------------------------------------
    bihp_state_t state;
    bihp_cycle_t kind;
    logic [1:0]  edge_cnt;
    logic        wr_done;
    logic [5:0]  addr_hold;
    logic [7:0]  wdata_hold;
    logic        rd_act;
    logic        wr_act;
    logic        ia_act;
    logic        cyc_act;
    logic        cyc_start;
    logic        cyc_end;
    logic        go_ack;
    logic        wr_commit;
    logic        cur_load;

    assign rd_act    = !pins.chip_select_n && !pins.read_strobe_n;
    assign wr_act    = !pins.chip_select_n && !pins.write_strobe_n;
    assign ia_act    = !pins.int_ack_n;
    assign cyc_act   = rd_act || wr_act || ia_act;
    assign cyc_start = (state == ST_IDLE) && cyc_act;
    assign cyc_end   = (state != ST_IDLE) && !cyc_act;
    assign go_ack    = (state == ST_WAIT) && cyc_act && (edge_cnt >= `BIHP_ACK_EDGES - 2'h1);

    // earliest of acknowledge or strobe end
    // plain mode lands at strobe end
    assign wr_commit = (kind == CY_WR) && !wr_done && (go_ack || cyc_end);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state    <= ST_IDLE;
            kind     <= CY_NONE;
            edge_cnt <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cyc_act) begin
                        kind     <= ia_act ? CY_IA : (wr_act ? CY_WR : CY_RD);
                        edge_cnt <= 2'h1;
                        state    <= ack_en ? ST_WAIT : ST_HOLD;
                    end
                end
                ST_WAIT: begin
                    if (!cyc_act) begin
                        state <= ST_IDLE;
                    end else if (go_ack) begin
                        state <= ST_ACK;
                    end else begin
                        edge_cnt <= edge_cnt + 2'h1;
                    end
                end
                ST_ACK, ST_HOLD: begin
                    if (!cyc_act) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // address and data held from the last active bus cycle of any kind: read, write or interrupt acknowledge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            addr_hold  <= 6'h00;
            wdata_hold <= 8'h00;
            wr_done    <= 1'b0;
        end else begin
            if (cyc_act) begin
                addr_hold  <= pins.addr;
                wdata_hold <= pins.data;
            end
            if (state == ST_IDLE) begin
                wr_done <= 1'b0;
            end else if (wr_commit) begin
                wr_done <= 1'b1;
            end
        end
    end

    // acknowledge only once data is valid or written
    assign data_ack_oe = (state == ST_ACK);

    // ----------------------------------------------------------------
    // register writes and commands
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            interrupt_control <= `BIHP_RST_CTRL;
            vector_base       <= `BIHP_RST_VBASE;
            interrupt_mask    <= `BIHP_RST_MASK;
        end else if (wr_commit) begin
            case (addr_hold)
                `BIHP_OFS_CTRL:  interrupt_control     <= wdata_hold;
                `BIHP_OFS_VBASE: vector_base           <= wdata_hold;
                `BIHP_OFS_MASK0: interrupt_mask[7:0]   <= wdata_hold;
                `BIHP_OFS_MASK1: interrupt_mask[15:8]  <= wdata_hold;
                `BIHP_OFS_MASK2: interrupt_mask[17:16] <= wdata_hold[1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ack_en <= `BIHP_RST_ACK_EN;
        end else if (wr_commit && addr_hold == `BIHP_CMD_ACK_ON) begin
            ack_en <= 1'b1;
        end else if (wr_commit && addr_hold == `BIHP_CMD_ACK_OFF) begin
            ack_en <= 1'b0;
        end
    end

    assign cur_load = (cyc_start && ia_act) || (wr_commit && addr_hold == `BIHP_CMD_CUR_UPD);

    // winner byte already holds count, type, channel
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            current_interrupt <= `BIHP_RST_CUR;
        end else if (cur_load) begin
            current_interrupt <= winner;
        end
    end

    // ----------------------------------------------------------------
    // read data and vector
    // ----------------------------------------------------------------
    function automatic logic [7:0] vector_of(input logic [1:0] fmt, input logic [7:0] base, input logic [7:0] cur);
        case (fmt)
            `BIHP_FMT_FULL: vector_of = base;
            `BIHP_FMT_CHAN: vector_of = {base[7:2], cur[1:0]};
            `BIHP_FMT_TYPE: vector_of = {base[7:5], cur[4:2], cur[1:0]};
            default:        vector_of = `BIHP_ALL_ONES;
        endcase
    endfunction

    logic [7:0] next_data_out;

    always_comb begin
        next_data_out = 8'h00;
        if (ia_act) begin
            next_data_out = vector_of(interrupt_control[1:0], vector_base, current_interrupt);
        end else begin
            case (pins.addr)
                `BIHP_OFS_CTRL:  next_data_out = interrupt_control;
                `BIHP_OFS_VBASE: next_data_out = vector_base;
                `BIHP_OFS_MASK0: next_data_out = interrupt_mask[7:0];
                `BIHP_OFS_MASK1: next_data_out = interrupt_mask[15:8];
                `BIHP_OFS_MASK2: next_data_out = {6'h00, interrupt_mask[17:16]};
                `BIHP_OFS_CUR:   next_data_out = current_interrupt;
                default:         next_data_out = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            data_out <= 8'h00;
        end else begin
            data_out <= next_data_out;
        end
    end

    // drive from strobe start, release at first rise
    assign data_oe = (state != ST_IDLE) && (kind != CY_WR) && (rd_act || ia_act);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_irq_follows: assert property (@(posedge mclk) disable iff (!nrst)
        (over && $past(over)) |-> int_req_oe)
        else $error("request not held while bid exceeds threshold");

    a_irq_release: assert property (@(posedge mclk) disable iff (!nrst)
        !over |=> !int_req_oe)
        else $error("request held with no bid over threshold");

    a_cur_only_load: assert property (@(posedge mclk) disable iff (!nrst)
        !cur_load |=> $stable(current_interrupt))
        else $error("current interrupt changed without a load");

    a_cur_iack_grab: assert property (@(posedge mclk) disable iff (!nrst)
        (cyc_start && ia_act) |=> current_interrupt == $past(winner))
        else $error("acknowledge cycle did not latch the winner");

    a_ack_two_edges: assert property (@(posedge mclk) disable iff (!nrst)
        (cyc_start && ack_en) ##1 cyc_act |=> data_ack_oe)
        else $error("acknowledge not asserted two edges after start");

    a_ack_early: assert property (@(posedge mclk) disable iff (!nrst)
        cyc_start |=> !data_ack_oe)
        else $error("acknowledge asserted too early");

    a_ack_off_cmd: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_commit && addr_hold == `BIHP_CMD_ACK_OFF) |=> !ack_en ##1 (cyc_act || !data_ack_oe))
        else $error("acknowledge disable command ignored");

    a_vec_inhibit: assert property (@(posedge mclk) disable iff (!nrst)
        (ia_act && interrupt_control[1:0] == `BIHP_FMT_INHIBIT) |=> data_out == `BIHP_ALL_ONES)
        else $error("inhibited vector not all ones");

    a_tie_channel: assert property (@(posedge mclk) disable iff (!nrst)
        (bid_v[3] && bid_v[1] && bid[3][7:2] == bid[1][7:2] && winner[7:2] == bid[3][7:2])
        |-> winner[1:0] == 2'h3)
        else $error("tie not resolved to higher channel");

    a_plain_write: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_commit && state == ST_HOLD) |-> !cyc_act)
        else $error("plain mode write landed before strobe end");

endmodule

// ==== verif/bihp_host.sv ====
// host bus master model facing the bidding interrupt host port
`timescale 1ns/10ps
module bihp_host (
    // clock
    input  wire logic       mclk,
    // pins toward the device
    output logic            chip_select_n,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic            int_ack_n,
    output logic [5:0]      addr,
    output logic [7:0]      data_in,
    // answers from the device
    input  wire logic [7:0] data_out,
    input  wire logic       data_ack_oe,
    input  wire logic       data_oe,
    // read and vector results
    output logic            done,
    output logic [7:0]      rval,
    output logic            roe
);
    initial begin
        {chip_select_n, read_strobe_n, write_strobe_n, int_ack_n} = 4'hF;
        {addr, data_in, done, rval, roe} = 24'h0;
    end

    // ----------------------------------------------------------------
    // one bus cycle: k 0 read, 1 write, 2 interrupt acknowledge
    // ----------------------------------------------------------------
    // strobes never overlap, ack awaited when enabled
    task automatic cyc(input logic [1:0] k, input logic [5:0] a, input logic [7:0] d,
                       input logic ack, output logic s);
        int n;
        s = 1'b0;
        @(posedge mclk);
        chip_select_n  <= k == 2'h2;
        read_strobe_n  <= k != 2'h0;
        write_strobe_n <= k != 2'h1;
        int_ack_n      <= k != 2'h2;
        addr           <= a;
        data_in        <= d;
        for (n = 0; n < 20 && !s; n++) begin
            @(posedge mclk);
            s = data_ack_oe === 1'b1;
            if (!ack && n == 8) break;
        end
        rval <= data_out;
        roe  <= data_oe;
        done <= k != 2'h1;
        {chip_select_n, read_strobe_n, write_strobe_n, int_ack_n} <= 4'hF;
        // released bus must not look like held data
        data_in <= ~d;
        @(posedge mclk);
        done <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the bidding interrupt host port
`timescale 1ns/10ps
`include "bihp_cfg.svh"
module tb;
    import bihp_pkg::*;
    logic        mclk, nrst, done, s, ae;
    logic        cs_n, rd_n, wr_n, ia_n, doe, irq_n, irq_oe, ack_n, ack_oe, roe;
    logic [5:0]  addr;
    logic [7:0]  din, dout, rval, v;
    logic [7:0]  vx [4];
    logic [15:0] rx_fill, tx_free, rx_level, tx_level, lfsr;
    logic [3:0]  rx_error, break_seen, cos_seen, ct_prio;
    logic [1:0]  ct_timeout;
    logic [11:0] break_prio, cos_prio;
    int          err_count, checked, f;
    logic [7:0]  exp_q [$];
    string       nm_q [$];

    bihp_top #(.NUM_CH(4)) bihp_top_inst (
        .mclk(mclk), .nrst(nrst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .int_ack_n(ia_n), .addr(addr), .data_in(din),
        .data_out(dout), .data_oe(doe), .int_req_n_o(irq_n), .int_req_oe(irq_oe),
        .data_ack_n_o(ack_n), .data_ack_oe(ack_oe), .rx_fill(rx_fill), .tx_free(tx_free),
        .rx_level(rx_level), .tx_level(tx_level), .rx_error(rx_error),
        .break_seen(break_seen), .cos_seen(cos_seen), .ct_timeout(ct_timeout),
        .break_prio(break_prio), .cos_prio(cos_prio), .ct_prio(ct_prio));

    bihp_host bihp_host_inst (
        .mclk(mclk), .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .int_ack_n(ia_n), .addr(addr), .data_in(din), .data_out(dout),
        .data_ack_oe(ack_oe), .data_oe(doe), .done(done), .rval(rval), .roe(roe));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] ex);
        checked++;
        if (seen !== ex) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, ex, seen);
        end
    endtask

    task automatic final_report();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // c: whether the presence of the acknowledge is judged
    task automatic cyc(input logic [1:0] k, input logic [5:0] a, input logic [7:0] d, input logic c);
        bihp_host_inst.cyc(k, a, d, ae, s);
        if (c) chk("ack", {7'h0, s}, {7'h0, ae});
        if (c && ae && !s) final_report();
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] x, input string n);
        exp_q.push_back(x);
        nm_q.push_back(n);
        cyc(2'h0, a, 8'h00, 1'b1);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        cyc(2'h1, a, d, 1'b1);
    endtask

    task automatic irq(input logic e);
        repeat (10) @(posedge mclk);
        chk("irq", {7'h0, irq_oe}, {7'h0, e});
    endtask

    // each read or vector result against the oldest note
    always @(posedge mclk) begin
        if (done) begin
            chk(nm_q.pop_front(), rval, exp_q.pop_front());
            chk("data_oe", {7'h0, roe}, 8'h01);
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        lfsr = 16'hA951;
        {rx_fill, tx_free, rx_level, tx_level} = {16'h0, lfsr, 32'h0};
        {rx_error, break_seen, cos_seen, ct_prio, ct_timeout} = {4'h0, lfsr[7:0], 4'hF, 2'h0};
        {break_prio, cos_prio} = 24'h0;
        {ae, err_count, checked} = {1'b1, 64'h0};
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (6) @(posedge mclk);
        rd(`BIHP_OFS_CTRL, 8'h00, "ctrl");
        rd(`BIHP_OFS_VBASE, 8'h0F, "vbase");
        rd(`BIHP_OFS_CUR, 8'h00, "current");
        rd(6'h3F, 8'h00, "unmapped");
        lfsr = nx(nx(lfsr));
        v = lfsr[7:0];
        wr(`BIHP_OFS_VBASE, v);
        rd(`BIHP_OFS_VBASE, v, "vbase");
        // timer 0 alone, priority 11: silent until it times out
        wr(`BIHP_OFS_MASK2, 8'h01);
        irq(1'b0);
        ct_timeout <= 2'h1;
        irq(1'b1);
        chk("irq pin", {7'h0, irq_n}, 8'h00);
        chk("ack pin", {7'h0, ack_n}, 8'h00);
        // service starts by updating current interrupt
        wr(`BIHP_CMD_CUR_UPD, lfsr[15:8]);
        rd(`BIHP_OFS_CUR, 8'hD4, "current");
        // full receivers on B and D tie: D must win
        wr(`BIHP_OFS_MASK2, 8'h00);
        rx_fill <= 16'h8080;
        wr(`BIHP_OFS_MASK0, 8'h0F);
        irq(1'b1);
        rd(`BIHP_OFS_CUR, 8'hD4, "current held");
        vx = '{v, {v[7:2], 2'h3}, {v[7:5], 3'h3, 2'h3}, 8'hFF};
        for (f = 0; f < 4; f++) begin
            wr(`BIHP_OFS_CTRL, {6'h00, f[1:0]});
            exp_q.push_back(vx[f]);
            nm_q.push_back("vector");
            cyc(2'h2, 6'h00, 8'h00, 1'b1);
        end
        rd(`BIHP_OFS_CUR, 8'hEF, "current");
        wr(`BIHP_OFS_CTRL, 8'hEC);
        irq(1'b0);
        wr(`BIHP_OFS_CTRL, 8'hE8);
        irq(1'b1);
        wr(`BIHP_OFS_MASK0, 8'h00);
        irq(1'b0);
        wr(`BIHP_OFS_MASK0, 8'h0F);
        rx_fill <= 16'h0000;
        irq(1'b0);
        // acknowledge off: plain strobed cycles
        cyc(2'h1, `BIHP_CMD_ACK_OFF, 8'h00, 1'b0);
        ae = 1'b0;
        wr(`BIHP_OFS_CTRL, 8'h5C);
        rd(`BIHP_OFS_CTRL, 8'h5C, "ctrl no ack");
        cyc(2'h1, `BIHP_CMD_ACK_ON, 8'h00, 1'b0);
        ae = 1'b1;
        rd(`BIHP_OFS_CTRL, 8'h5C, "ctrl ack");
        // receiver D held back by its fill level, then bids with error
        rx_fill  <= 16'h4000;
        rx_level <= 16'h5000;
        rx_error <= 4'h8;
        irq(1'b0);
        rx_level <= 16'h4000;
        irq(1'b1);
        wr(`BIHP_CMD_CUR_UPD, 8'h00);
        rd(`BIHP_OFS_CUR, 8'hDF, "current rx error");
        // transmitters only, type modified vector
        wr(`BIHP_OFS_MASK0, 8'hF0);
        wr(`BIHP_OFS_CTRL, 8'h02);
        exp_q.push_back({v[7:5], 3'h6, 2'h3});
        nm_q.push_back("tx vector");
        cyc(2'h2, 6'h00, 8'h00, 1'b1);
        rd(`BIHP_OFS_CUR, 8'h7B, "current tx");
        repeat (4) @(posedge mclk);
        final_report();
    end
endmodule
